//--- mrs_loop_model.sv
`timescale 1ns/100ps
module mrs_loop_model (
    // clock and reset
    input logic mclk,
    input logic arst_n,
    // operating point asked by the bench
    input logic signed [15:0] speed_set,
    input logic signed [15:0] torque_set,
    // feedback towards the selector
    output logic signed [15:0] speed_act,
    output logic signed [15:0] out_freq,
    output logic signed [15:0] spd_ctrl_out
);
    logic signed [15:0] speed_q;
    logic signed [15:0] spd_q;

    ////////////////////////////////////////////////////////////////////////////
    // shaft lags the operating point by one cycle, so nothing is seen early
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            speed_q <= 16'sh0000;
        end else begin
            speed_q <= speed_set;
        end
    end

    // speed controller demand, also one cycle late
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            spd_q <= 16'sh0000;
        end else begin
            spd_q <= torque_set;
        end
    end

    // no slip modelled: output frequency follows the shaft
    assign speed_act = speed_q;
    assign out_freq = speed_q;
    assign spd_ctrl_out = spd_q;
endmodule

//--- mrs_lpf.sv
`timescale 1ns/100ps
module mrs_lpf
    import mrs_pkg::*;
(
    // clock and reset
    input logic mclk,
    input logic arst_n,
    // sample path
    input logic signed [15:0] din,
    input logic [3:0] tc_shift,
    output logic signed [15:0] dout
);

    logic signed [15:0] y_q;
    logic signed [16:0] err;
    logic signed [16:0] step;

    // first-order step; a shift keeps it multiplier free at the cost of
    // time constants in powers of two only
    always_comb begin
        err = 17'(din) - 17'(y_q);
        step = err >>> tc_shift;
    end

    // y stays between old y and din, so the narrowing cannot wrap
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            y_q <= REF_ZERO;
        end else begin
            y_q <= 16'(17'(y_q) + step);
        end
    end

    assign dout = y_q;

    filt_pass_a: assert property (@(posedge mclk) disable iff (!arst_n)
        tc_shift == 4'h0 |=> y_q == $past(din))
        else $error("filter with zero constant did not pass input");

endmodule

//--- mrs_pkg.sv
package mrs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // widths, reset values and fixed-point scaling
    localparam int REF_W = 16;
    localparam logic signed [15:0] REF_ZERO = 16'sh0000;
    localparam logic signed [31:0] SAT_HI = 32'sh0000_7FFF;
    localparam logic signed [31:0] SAT_LO = -32'sh0000_8000;
    localparam int AI_SHIFT = 15;  // analogue full scale is 2^15
    localparam int JOY_SHIFT = 15; // joystick full scale is +/- 2^15
    localparam int LS_SHIFT = 7;   // load share 8'h80 means 100 %
    localparam int RTF_SHIFT = 4;  // ramp multiplier 8'h10 means 1.0
    localparam logic [23:0] RAMP_SAT = 24'h00_FFFF;
    localparam logic [2:0] PRESET_NONE = 3'h0;
    localparam logic [14:0] MAG_ZERO = 15'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // torque source and speed cap selections
    typedef enum logic [3:0] {
        TSRC_NONE, TSRC_AI1, TSRC_AI2, TSRC_AI3, TSRC_AI4,
        TSRC_JOY1, TSRC_JOY2, TSRC_KEYPAD, TSRC_FIELDBUS, TSRC_MASTER
    } mrs_tsrc_t;

    typedef enum logic [2:0] {
        FORCED_SPEED_LOOP, FREQUENCY_CAP_ONLY, RAMP_BOUNDED,
        CAP_MIN, CAP_MAX, CAP_WINDOW
    } mrs_cap_t;

    typedef enum logic {BAND_BELOW, BAND_ABOVE} mrs_band_t;

    ////////////////////////////////////////////////////////////////////////////
    // saturating arithmetic used by mrs_ref_sel
    function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
        if (v > SAT_HI) return 16'sh7FFF;
        if (v < SAT_LO) return 16'sh8000;
        return v[15:0];
    endfunction

    function automatic logic signed [15:0] neg16(input logic signed [15:0] v);
        return sat16(-32'(v));
    endfunction

    function automatic logic signed [15:0] abs16(input logic signed [15:0] v);
        return v[15] ? neg16(v) : v;
    endfunction

    function automatic logic signed [15:0] dir16(input logic signed [15:0] v,
                                                 input logic rev);
        return rev ? neg16(v) : v;
    endfunction

    function automatic logic signed [31:0] mag32(input logic [14:0] m);
        return 32'(signed'({1'b0, m}));
    endfunction

    function automatic logic signed [15:0] clamp16(input logic signed [15:0] v,
                                                   input logic [14:0] m);
        if (32'(v) > mag32(m)) return 16'(mag32(m));
        if (32'(v) < -mag32(m)) return 16'(-mag32(m));
        return v;
    endfunction

endpackage

//--- mrs_ref_sel.sv
`timescale 1ns/100ps
module mrs_ref_sel
    import mrs_pkg::*;
(
    // clock and reset
    input logic mclk,
    input logic arst_n,
    // speed reference selection
    input logic jog_active,
    input logic reverse_cmd,
    input logic [2:0] preset_sel,
    input logic preset_main,
    input logic signed [15:0] main_ref,
    input logic signed [15:0] jog_speed,
    input logic signed [15:0] preset_speed [8],
    // inching
    input logic inch_enable,
    input logic inch1_cmd,
    input logic inch2_cmd,
    input logic start_cmd,
    input logic signed [15:0] inch_ref1,
    input logic signed [15:0] inch_ref2,
    // prohibited band and ramp
    input logic signed [15:0] band_lo,
    input logic signed [15:0] band_hi,
    input logic signed [15:0] out_freq,
    input logic [15:0] ramp_time,
    input logic [7:0] band_ramp_multiplier,
    // torque sources and scaling
    input logic [3:0] tq_src_sel,
    input logic [14:0] tq_ai [4],
    input logic signed [15:0] tq_joy [2],
    input logic signed [15:0] tq_keypad,
    input logic signed [15:0] tq_fieldbus,
    input logic signed [15:0] tq_master,
    input logic [14:0] tq_max,
    input logic signed [15:0] tq_min,
    input logic [7:0] load_share,
    input logic [3:0] torque_filter_tc,
    input logic [14:0] torque_deadband,
    // torque mode speed limiting
    input logic torque_ctrl_en,
    input logic openloop,
    input logic [2:0] torque_mode_speed_cap,
    input logic signed [15:0] spd_ctrl_out,
    input logic [14:0] max_freq,
    input logic [14:0] pos_freq_lim,
    input logic [14:0] neg_freq_lim,
    input logic signed [15:0] ramp_out,
    input logic signed [15:0] final_speed_target,
    input logic signed [15:0] speed_act,
    input logic [14:0] win_pos,
    input logic [14:0] win_neg,
    input logic [14:0] win_pos_off,
    input logic [14:0] win_neg_off,
    input logic [14:0] openloop_torque_floor,
    // results to the control loop
    output logic signed [15:0] speed_ref,
    output logic inch_run,
    output logic [15:0] ramp_time_eff,
    output logic signed [15:0] torque_ref,
    output logic torque_mode,
    output logic window_armed,
    output logic signed [15:0] spd_lim_pos,
    output logic signed [15:0] spd_lim_neg
);

    default clocking dclk @(posedge mclk); endclocking
    default disable iff (!arst_n);

    ////////////////////////////////////////////////////////////////////////////
    // speed reference selection

    logic inch_armed_q, inch_run_q, inch_go;
    logic signed [15:0] jog_dir, preset_dir, zero_dir, inch_val;
    logic signed [15:0] sel_ref_d, sel_ref_q, speed_ref_q;

    // inching only counts when enable came first and no start is held
    assign inch_go = inch_armed_q && (inch1_cmd || inch2_cmd) && !start_cmd;
    assign inch_val = inch1_cmd ? inch_ref1 : inch_ref2;
    assign jog_dir = dir16(jog_speed, reverse_cmd);
    assign preset_dir = dir16(preset_speed[preset_sel], reverse_cmd);
    assign zero_dir = dir16(preset_speed[0], reverse_cmd);

    // priority: inching, jog, preset inputs, preset zero, main reference
    always_comb begin
        if (inch_go) begin
            sel_ref_d = inch_val;
        end else if (jog_active) begin
            sel_ref_d = jog_dir;
        end else if (preset_sel != PRESET_NONE) begin
            sel_ref_d = preset_dir;
        end else if (preset_main) begin
            sel_ref_d = zero_dir;
        end else begin
            sel_ref_d = main_ref;
        end
    end

    // arm drops with enable; a command already held when enable rises
    // must be released before it is accepted
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            inch_armed_q <= 1'b0;
            inch_run_q <= 1'b0;
        end else begin
            inch_armed_q <= inch_enable && (inch_armed_q || !(inch1_cmd || inch2_cmd));
            inch_run_q <= inch_go;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sel_ref_q <= REF_ZERO;
        end else begin
            sel_ref_q <= sel_ref_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // prohibited band hold and ramp scaling

    mrs_band_t band_q;
    logic band_en, in_band, fout_in_band;
    logic [23:0] ramp_prod;
    logic [15:0] ramp_eff_q;

    assign band_en = band_hi > band_lo;
    assign in_band = band_en && sel_ref_q > band_lo && sel_ref_q <= band_hi;
    assign fout_in_band = band_en && out_freq >= band_lo && out_freq <= band_hi;
    assign ramp_prod = 24'(ramp_time * band_ramp_multiplier) >> RTF_SHIFT;

    // side of the band last seen outside it decides which edge is held
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            band_q <= BAND_BELOW;
        end else if (sel_ref_q <= band_lo) begin
            band_q <= BAND_BELOW;
        end else if (sel_ref_q > band_hi) begin
            band_q <= BAND_ABOVE;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            speed_ref_q <= REF_ZERO;
        end else if (in_band) begin
            speed_ref_q <= (band_q == BAND_BELOW) ? band_lo : band_hi;
        end else begin
            speed_ref_q <= sel_ref_q;
        end
    end

    // saturate instead of wrapping when the multiplier is large
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ramp_eff_q <= 16'h0000;
        end else if (fout_in_band) begin
            ramp_eff_q <= (ramp_prod > RAMP_SAT) ? 16'hFFFF : ramp_prod[15:0];
        end else begin
            ramp_eff_q <= ramp_time;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // torque source, scaling, load share, filter and deadband

    logic signed [15:0] ai_scaled [4];
    logic signed [15:0] joy_scaled [2];
    logic signed [15:0] tq_raw, tq_ls, tq_filt, tq_db;

    // analogue inputs span torque minimum to torque maximum
    for (genvar i = 0; i < 4; i++) begin : g_ai
        logic signed [31:0] span;
        assign span = (mag32(tq_max) - 32'(tq_min)) * mag32(tq_ai[i]);
        assign ai_scaled[i] = sat16(32'(tq_min) + (span >>> AI_SHIFT));
    end

    // joystick spans the negated maximum to the maximum
    for (genvar j = 0; j < 2; j++) begin : g_joy
        logic signed [31:0] prod;
        assign prod = mag32(tq_max) * 32'(tq_joy[j]);
        assign joy_scaled[j] = sat16(prod >>> JOY_SHIFT);
    end

    // codes ten and up are not sources and read as none
    always_comb begin
        unique case (mrs_tsrc_t'(tq_src_sel))
            TSRC_AI1: tq_raw = ai_scaled[0];
            TSRC_AI2: tq_raw = ai_scaled[1];
            TSRC_AI3: tq_raw = ai_scaled[2];
            TSRC_AI4: tq_raw = ai_scaled[3];
            TSRC_JOY1: tq_raw = joy_scaled[0];
            TSRC_JOY2: tq_raw = joy_scaled[1];
            TSRC_KEYPAD: tq_raw = tq_keypad;
            TSRC_FIELDBUS: tq_raw = tq_fieldbus;
            TSRC_MASTER: tq_raw = tq_master;
            default: tq_raw = REF_ZERO;
        endcase
    end

    // load share widened as signed so negative torque keeps its sign through the shift
    assign tq_ls = sat16((32'(tq_raw) * 32'(signed'({1'b0, load_share}))) >>> LS_SHIFT);

    // filter sits between load share and the deadband stage
    mrs_lpf u_lpf (
        .mclk(mclk),
        .arst_n(arst_n),
        .din(tq_ls),
        .tc_shift(torque_filter_tc),
        .dout(tq_filt)
    );

    assign tq_db = (torque_deadband != MAG_ZERO &&
                    32'(abs16(tq_filt)) <= mag32(torque_deadband)) ? REF_ZERO : tq_filt;

    ////////////////////////////////////////////////////////////////////////////
    // torque mode, speed limits and window control

    mrs_cap_t cap;
    logic torque_mode_d, torque_mode_q, offs_zero, win_edge, win_inside;
    logic window_armed_q;
    logic [14:0] lim_p, lim_n;
    logic signed [31:0] sp, tgt;
    logic signed [15:0] tq_sel, torque_ref_q, lim_hi_d, lim_lo_d, lim_hi_q, lim_lo_q;

    assign cap = mrs_cap_t'(torque_mode_speed_cap);
    assign sp = 32'(speed_act);
    assign tgt = 32'(final_speed_target);
    assign offs_zero = win_pos_off == MAG_ZERO && win_neg_off == MAG_ZERO;
    assign lim_p = offs_zero ? win_pos : win_pos_off;
    assign lim_n = offs_zero ? win_neg : win_neg_off;
    assign win_edge = cap == CAP_WINDOW &&
                      (sp >= tgt + mag32(win_pos) || sp <= tgt - mag32(win_neg));
    assign win_inside = sp < tgt + mag32(lim_p) && sp > tgt - mag32(lim_n);

    // open loop falls back below the floor; cap zero is a mode switch
    assign torque_mode_d = torque_ctrl_en && cap != FORCED_SPEED_LOOP &&
        !(openloop && 32'(abs16(out_freq)) < mag32(openloop_torque_floor));

    // window controller arms at the window edge and drops once back inside
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            window_armed_q <= 1'b0;
        end else if (cap != CAP_WINDOW) begin
            window_armed_q <= 1'b0;
        end else if (win_edge) begin
            window_armed_q <= 1'b1;
        end else if (win_inside) begin
            window_armed_q <= 1'b0;
        end
    end

    always_comb begin
        unique case (cap)
            FREQUENCY_CAP_ONLY: begin
                lim_hi_d = 16'(mag32(pos_freq_lim < max_freq ? pos_freq_lim : max_freq));
                lim_lo_d = 16'(-mag32(neg_freq_lim < max_freq ? neg_freq_lim : max_freq));
            end
            RAMP_BOUNDED: begin
                lim_hi_d = abs16(ramp_out);
                lim_lo_d = neg16(abs16(ramp_out));
            end
            CAP_WINDOW: begin
                lim_hi_d = sat16(tgt + mag32(lim_p));
                lim_lo_d = sat16(tgt - mag32(lim_n));
            end
            default: begin
                lim_hi_d = 16'(mag32(max_freq));
                lim_lo_d = 16'(-mag32(max_freq));
            end
        endcase
    end

    // speed controller output takes over outside torque mode
    always_comb begin
        if (!torque_mode_d) begin
            tq_sel = spd_ctrl_out;
        end else begin
            unique case (cap)
                CAP_MIN: tq_sel = (spd_ctrl_out < tq_db) ? spd_ctrl_out : tq_db;
                CAP_MAX: tq_sel = (spd_ctrl_out > tq_db) ? spd_ctrl_out : tq_db;
                CAP_WINDOW: tq_sel = window_armed_q ? spd_ctrl_out : tq_db;
                default: tq_sel = tq_db;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            torque_ref_q <= REF_ZERO;
            torque_mode_q <= 1'b0;
            lim_hi_q <= REF_ZERO;
            lim_lo_q <= REF_ZERO;
        end else begin
            torque_ref_q <= clamp16(tq_sel, tq_max);
            torque_mode_q <= torque_mode_d;
            lim_hi_q <= lim_hi_d;
            lim_lo_q <= lim_lo_d;
        end
    end

    assign speed_ref = speed_ref_q;
    assign inch_run = inch_run_q;
    assign ramp_time_eff = ramp_eff_q;
    assign torque_ref = torque_ref_q;
    assign torque_mode = torque_mode_q;
    assign window_armed = window_armed_q;
    assign spd_lim_pos = lim_hi_q;
    assign spd_lim_neg = lim_lo_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    jog_dir_a: assert property (jog_active && !inch_go |=> sel_ref_q == $past(jog_dir))
        else $error("jog reference not selected with direction");

    jog_prio_a: assert property (jog_active && !inch_go && preset_sel != PRESET_NONE
        |=> sel_ref_q != $past(preset_dir) || $past(preset_dir) == $past(jog_dir))
        else $error("preset won over jog");

    preset_idx_a: assert property (!inch_go && !jog_active && preset_sel != PRESET_NONE
        |=> sel_ref_q == $past(preset_dir))
        else $error("preset index not honoured");

    preset_zero_a: assert property (!inch_go && !jog_active && preset_sel == PRESET_NONE
        && preset_main |=> sel_ref_q == $past(zero_dir))
        else $error("preset zero not used");

    inch_start_a: assert property (inch_go |=> inch_run_q)
        else $error("inching did not start");

    inch_arm_a: assert property (!inch_enable |=> ##1 !inch_run_q)
        else $error("inching ran without prior enable");

    inch_block_a: assert property (start_cmd |=> !inch_run_q)
        else $error("inching ran during start command");

    inch_dir_a: assert property (inch_go |=> sel_ref_q == $past(inch_val))
        else $error("inching reference altered");

    tq_clamp_a: assert property (##1 32'(abs16(torque_ref_q)) <= mag32($past(tq_max)))
        else $error("torque reference above maximum");

    speed_mode_a: assert property (cap == FORCED_SPEED_LOOP |=> !torque_mode_q)
        else $error("torque mode while speed control forced");

    ol_floor_a: assert property (openloop && 32'(abs16(out_freq))
        < mag32(openloop_torque_floor) |=> !torque_mode_q)
        else $error("open loop torque below floor");

    band_hold_a: assert property (in_band && band_q == BAND_BELOW
        |=> speed_ref_q == $past(band_lo))
        else $error("band low limit not held");

    ramp_scale_a: assert property (fout_in_band && band_ramp_multiplier == 8'h20
        && !ramp_time[15] |=> ramp_eff_q == {$past(ramp_time[14:0]), 1'b0})
        else $error("double band multiplier did not double ramp");

    sequence win_hit_s;
        win_edge && !window_armed_q;
    endsequence

    sequence win_hold_s;
        ##1 window_armed_q;
    endsequence

    window_arm_a: assert property (win_hit_s |-> win_hold_s)
        else $error("window edge did not arm controller");

    window_lim_a: assert property (cap == CAP_WINDOW && offs_zero
        |=> lim_hi_q == $past(sat16(tgt + mag32(win_pos))))
        else $error("window size not used as limit");

endmodule

//--- tb_motor_reference_selector.sv
`timescale 1ns/100ps
module tb_motor_reference_selector;
    logic mclk = 1'b0, arst_n = 1'b0, jog_active = 1'b0, reverse_cmd = 1'b0;
    logic preset_main = 1'b0, inch_enable = 1'b0, inch1_cmd = 1'b0, inch2_cmd = 1'b0;
    logic start_cmd = 1'b0, torque_ctrl_en = 1'b0, openloop = 1'b0;
    logic [2:0] preset_sel = 3'h0, torque_mode_speed_cap = 3'h2;
    logic signed [15:0] main_ref = 16'sh0123, jog_speed = 16'sh0309, inch_ref1 = 16'sh0000;
    logic signed [15:0] inch_ref2 = 16'sh0000, band_lo = 16'sh0000, band_hi = 16'sh0000;
    logic signed [15:0] tq_keypad = 16'sh006F, tq_fieldbus = 16'sh0000, tq_master = 16'sh014D;
    logic signed [15:0] tq_min = 16'sh0190, ramp_out = -16'sh04B0, final_speed_target = 16'sh03E8;
    logic signed [15:0] speed_set = 16'sh0000, torque_set = 16'sh02BC;
    logic signed [15:0] preset_speed [8] = '{16'sh0032, 16'sh0096, 16'sh00FA, 16'sh015E,
        16'sh01C2, 16'sh0226, 16'sh028A, 16'sh02EE};
    logic signed [15:0] tq_joy [2] = '{-16'sh8000, 16'sh4000};
    logic [14:0] tq_ai [4] = '{15'h0000, 15'h4000, 15'h6000, 15'h2000};
    logic [15:0] ramp_time = 16'h0064;
    logic [7:0] band_ramp_multiplier = 8'h20, load_share = 8'h40;
    logic [3:0] tq_src_sel = 4'h8, torque_filter_tc = 4'h1;
    logic [14:0] tq_max = 15'h07D0, torque_deadband = 15'h0000, max_freq = 15'h1388;
    logic [14:0] pos_freq_lim = 15'h0BB8, neg_freq_lim = 15'h1770, win_pos = 15'h0064;
    logic [14:0] win_neg = 15'h0064, win_pos_off = 15'h0000, win_neg_off = 15'h0000;
    logic [14:0] openloop_torque_floor = 15'h0064;
    logic signed [15:0] speed_act, out_freq, spd_ctrl_out, speed_ref, torque_ref;
    logic signed [15:0] spd_lim_pos, spd_lim_neg;
    logic [15:0] ramp_time_eff;
    logic inch_run, torque_mode, window_armed;
    int err_count = 0;
    int checks = 0;
    // expected torque per source selection 0..9
    logic signed [15:0] tq_exp [10] = '{16'sh0000, 16'sh0190, 16'sh04B0, 16'sh0640,
        16'sh0320, -16'sh07D0, 16'sh03E8, 16'sh006F, 16'sh00DE, 16'sh014D};

    ////////////////////////////////////////////////////////////////////////////
    mrs_ref_sel mrs_ref_sel_i (.mclk(mclk), .arst_n(arst_n), .jog_active(jog_active),
        .reverse_cmd(reverse_cmd), .preset_sel(preset_sel), .preset_main(preset_main),
        .main_ref(main_ref), .jog_speed(jog_speed), .preset_speed(preset_speed),
        .inch_enable(inch_enable), .inch1_cmd(inch1_cmd), .inch2_cmd(inch2_cmd),
        .start_cmd(start_cmd), .inch_ref1(inch_ref1), .inch_ref2(inch_ref2),
        .band_lo(band_lo), .band_hi(band_hi), .out_freq(out_freq), .ramp_time(ramp_time),
        .band_ramp_multiplier(band_ramp_multiplier), .tq_src_sel(tq_src_sel), .tq_ai(tq_ai),
        .tq_joy(tq_joy), .tq_keypad(tq_keypad), .tq_fieldbus(tq_fieldbus),
        .tq_master(tq_master), .tq_max(tq_max), .tq_min(tq_min), .load_share(load_share),
        .torque_filter_tc(torque_filter_tc), .torque_deadband(torque_deadband),
        .torque_ctrl_en(torque_ctrl_en), .openloop(openloop),
        .torque_mode_speed_cap(torque_mode_speed_cap), .spd_ctrl_out(spd_ctrl_out),
        .max_freq(max_freq), .pos_freq_lim(pos_freq_lim), .neg_freq_lim(neg_freq_lim),
        .ramp_out(ramp_out), .final_speed_target(final_speed_target), .speed_act(speed_act),
        .win_pos(win_pos), .win_neg(win_neg), .win_pos_off(win_pos_off),
        .win_neg_off(win_neg_off), .openloop_torque_floor(openloop_torque_floor),
        .speed_ref(speed_ref), .inch_run(inch_run), .ramp_time_eff(ramp_time_eff),
        .torque_ref(torque_ref), .torque_mode(torque_mode), .window_armed(window_armed),
        .spd_lim_pos(spd_lim_pos), .spd_lim_neg(spd_lim_neg));

    mrs_loop_model mrs_loop_model_i (.mclk(mclk), .arst_n(arst_n), .speed_set(speed_set),
        .torque_set(torque_set), .speed_act(speed_act), .out_freq(out_freq),
        .spd_ctrl_out(spd_ctrl_out));

    ////////////////////////////////////////////////////////////////////////////
    // clock, 10 ns period
    initial begin
        forever #5 mclk = ~mclk;
    end

    // compare and count
    task automatic chk(input logic signed [15:0] seen, input logic signed [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %0d expected %0d", $time, seen, exp);
        end
    endtask

    // inputs always move 1 ns after the edge
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic close_out();
        if (err_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_speed();
        for (int i = 1; i < 8; i++) begin
            preset_sel = 3'(i);
            reverse_cmd = 1'b1;
            step(4);
            chk(speed_ref, -preset_speed[i]);
        end
        jog_active = 1'b1;
        step(2);
        chk(speed_ref, -16'sh0309);
        jog_active = 1'b0;
        reverse_cmd = 1'b0;
        preset_sel = 3'h0;
        preset_main = 1'b1;
        step(4);
        chk(speed_ref, 16'sh0032);
        preset_main = 1'b0;
    endtask

    // a command before arming and one under start must both be ignored
    task automatic t_inch();
        inch1_cmd = 1'b1;
        inch_ref1 = -16'sh0064;
        reverse_cmd = 1'b1;
        step(4);
        chk(16'(inch_run), 16'sh0000);
        inch1_cmd = 1'b0;
        inch_enable = 1'b1;
        step(2);
        inch1_cmd = 1'b1;
        start_cmd = 1'b1;
        step(4);
        chk(16'(inch_run), 16'sh0000);
        inch1_cmd = 1'b0;
        start_cmd = 1'b0;
        step(2);
        inch1_cmd = 1'b1;
        for (int n = 0; n < 4 && inch_run !== 1'b1; n++) begin
            step(1);
        end
        chk(16'(inch_run), 16'sh0001);
        if (inch_run !== 1'b1) begin
            close_out();
        end
        step(2);
        chk(speed_ref, -16'sh0064);
        inch1_cmd = 1'b0;
        inch2_cmd = 1'b1;
        inch_ref2 = 16'sh0096;
        step(4);
        chk(speed_ref, 16'sh0096);
        inch2_cmd = 1'b0;
        inch_enable = 1'b0;
        reverse_cmd = 1'b0;
    endtask

    // rising into the band holds low, coming back from above holds high
    task automatic t_band();
        band_lo = 16'sh03E8;
        band_hi = 16'sh07D0;
        main_ref = 16'sh05DC;
        speed_set = 16'sh05DC;
        step(4);
        chk(speed_ref, 16'sh03E8);
        chk(ramp_time_eff, 16'sh00C8);
        main_ref = 16'sh0834;
        speed_set = 16'sh0032;
        step(4);
        chk(speed_ref, 16'sh0834);
        chk(ramp_time_eff, 16'sh0064);
        main_ref = 16'sh05DC;
        step(4);
        chk(speed_ref, 16'sh07D0);
    endtask

    // load share at half with a one-bit filter shift, then each source and the deadband
    task automatic t_torque();
        logic signed [15:0] db_in [6];
        logic signed [15:0] db_out [6];
        db_in = '{16'sh01F4, 16'sh012C, -16'sh012C, -16'sh012D, 16'sh0BB8, -16'sh0BB8};
        db_out = '{16'sh01F4, 16'sh0000, 16'sh0000, -16'sh012D, 16'sh07D0, -16'sh07D0};
        torque_ctrl_en = 1'b1;
        step(4);
        tq_fieldbus = 16'sh03E8;
        step(2);
        chk(torque_ref, 16'sh00FA);
        step(1);
        chk(torque_ref, 16'sh0177);
        load_share = 8'h80;
        torque_filter_tc = 4'h0;
        tq_fieldbus = 16'sh00DE;
        for (int s = 0; s < 10; s++) begin
            tq_src_sel = 4'((s + 9) % 10);
            step(4);
            chk(torque_ref, tq_exp[(s + 9) % 10]);
        end
        torque_deadband = 15'h012C;
        for (int k = 0; k < 6; k++) begin
            tq_fieldbus = db_in[k];
            step(4);
            chk(torque_ref, db_out[k]);
        end
        torque_deadband = 15'h0000;
        tq_fieldbus = 16'sh00DE;
    endtask

    // cap selections 0 to 4: torque, mode flag and speed limits
    task automatic t_caps();
        logic signed [15:0] t_exp [5];
        logic signed [15:0] p_exp [5];
        logic signed [15:0] n_exp [5];
        t_exp = '{16'sh02BC, 16'sh00DE, 16'sh00DE, 16'sh00DE, 16'sh02BC};
        p_exp = '{16'sh1388, 16'sh0BB8, 16'sh04B0, 16'sh1388, 16'sh1388};
        n_exp = '{-16'sh1388, -16'sh1388, -16'sh04B0, -16'sh1388, -16'sh1388};
        for (int c = 0; c < 5; c++) begin
            torque_mode_speed_cap = 3'(c);
            step(4);
            chk(torque_ref, t_exp[c]);
            chk(16'(torque_mode), (c == 0) ? 16'sh0000 : 16'sh0001);
            chk(spd_lim_pos, p_exp[c]);
            chk(spd_lim_neg, n_exp[c]);
        end
        torque_mode_speed_cap = 3'h2;
        openloop = 1'b1;
        step(4);
        chk(16'(torque_mode), 16'sh0000);
        speed_set = 16'sh0096;
        step(4);
        chk(16'(torque_mode), 16'sh0001);
        openloop = 1'b0;
    endtask

    task automatic t_window();
        torque_mode_speed_cap = 3'h5;
        speed_set = 16'sh03E8;
        step(4);
        chk(16'(window_armed), 16'sh0000);
        chk(spd_lim_pos, 16'sh044C);
        chk(spd_lim_neg, 16'sh0384);
        speed_set = 16'sh044C;
        step(4);
        chk(16'(window_armed), 16'sh0001);
        chk(torque_ref, 16'sh02BC);
        win_pos_off = 15'h0032;
        win_neg_off = 15'h0032;
        step(4);
        chk(spd_lim_pos, 16'sh041A);
        chk(spd_lim_neg, 16'sh03B6);
        speed_set = 16'sh03E8;
        step(4);
        chk(16'(window_armed), 16'sh0000);
        chk(torque_ref, 16'sh00DE);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence: outputs stay zero in reset, then each scenario in turn
    initial begin
        step(15);
        chk(speed_ref, 16'sh0000);
        chk(torque_ref, 16'sh0000);
        step(1);
        arst_n = 1'b1;
        step(2);
        chk(speed_ref, 16'sh0123);
        t_speed();
        t_inch();
        t_band();
        t_torque();
        t_caps();
        t_window();
        close_out();
    end
endmodule
